// ---- clip_map.vh ----
`ifndef CLIP_MAP_VH
`define CLIP_MAP_VH

// Loop current from the converter, unsigned, one count per microampere
`define CLIP_CUR_W          16
`define CLIP_UA_WIRE_BREAK  16'd3200
`define CLIP_UA_SPAN_LO     16'd4000
`define CLIP_UA_SPAN_HI     16'd20000
`define CLIP_UA_OVERFLOW    16'd21500

// Scaling: code = (ua - 4000) * 16774 >> 16, giving 000h..FFFh over 4..20 mA
`define CLIP_SCALE_K        15'h4186
`define CLIP_SCALE_SHIFT    16
`define CLIP_PROD_W         31
`define CLIP_CODE_MAX       12'hfff
`define CLIP_CODE_MIN       12'h000

// Measurement word layout
`define CLIP_BIT_WIRE_BREAK 12
`define CLIP_BIT_BELOW_SPAN 13
`define CLIP_BIT_ABOVE_SPAN 14
`define CLIP_BIT_OVERFLOW   15

// Status byte layout
`define CLIP_BIT_SW0        0
`define CLIP_BIT_SW1        1
`define CLIP_BIT_LIMIT0     2
`define CLIP_NUM_LIMITS     3

// Output byte layout
`define CLIP_BIT_SWITCH_OUT 0

// Register offsets on the plain register port
`define CLIP_ADDR_W         8
`define CLIP_REG_LIMIT0     8'h00
`define CLIP_REG_LIMIT1     8'h04
`define CLIP_REG_LIMIT2     8'h08
`define CLIP_REG_IRQ_STAT   8'h0c
`define CLIP_REG_IRQ_CLR    8'h10
`define CLIP_REG_IRQ_EN     8'h14
`define CLIP_REG_MEAS       8'h18
`define CLIP_REG_STATUS     8'h1c

// Limit reset values, microamperes
`define CLIP_LIMIT0_RST     16'd8000
`define CLIP_LIMIT1_RST     16'd12000
`define CLIP_LIMIT2_RST     16'd16000

// Interrupt status layout
`define CLIP_IRQ_W          4
`define CLIP_IRQ_WIRE_BREAK 0
`define CLIP_IRQ_OVERFLOW   1
`define CLIP_IRQ_SHORT      2
`define CLIP_IRQ_LIMIT      3

// Red flash half period
`define CLIP_FLASH_HALF_MS  250
`define CLIP_CLK_KHZ        100000

`endif

// ---- clip_sync.v ----
module clip_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_sys_rst,
    // Pin side
    input  wire [WIDTH-1:0] i_pin,
    // Clean level
    output reg  [WIDTH-1:0] o_level
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    integer k;

    // A bit only moves once the last two stages agree
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_reg  <= {WIDTH{1'b0}};
            s2_reg  <= {WIDTH{1'b0}};
            s3_reg  <= {WIDTH{1'b0}};
            o_level <= {WIDTH{1'b0}};
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (k = 0; k < WIDTH; k = k + 1) begin
                if (s2_reg[k] == s3_reg[k]) begin
                    o_level[k] <= s3_reg[k];
                end
            end
        end
    end

endmodule

// ---- clip_blink.v ----
module clip_blink #(
    parameter HALF_CYCLES = 25000000,
    parameter CNT_W       = 25
) (
    // Clock and reset
    input  wire i_clk,
    input  wire i_sys_rst,
    // Run only while flashing is wanted
    input  wire i_run,
    // Flash phase
    output reg  o_phase
);

    reg [CNT_W-1:0] cnt_reg;

    // Restart from lit so a flash is visible at once
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= {CNT_W{1'b0}};
            o_phase <= 1'b1;
        end else if (!i_run) begin
            cnt_reg <= {CNT_W{1'b0}};
            o_phase <= 1'b1;
        end else if (cnt_reg == HALF_CYCLES[CNT_W-1:0] - 1'b1) begin
            cnt_reg <= {CNT_W{1'b0}};
            o_phase <= ~o_phase;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

endmodule

// ---- clip_top.v ----
`include "clip_map.vh"

// Operation
// R1 - The module exposes three input process bytes and takes one output process byte.
// R2 - The scaled current sits in bits 11 to 0 of the word made of input bytes 0 and 1.
// R3 - Overflow is bit 15, above-span bit 14, below-span bit 13 and wire break bit 12.
// R4 - Wire break is set below 3.2 mA and below-span between 3.2 and 4.0 mA.
// R5 - Above-span is set between 20 and 21.5 mA and overflow above 21.5 mA.
// R6 - 4.0 mA codes as 000h and 20.0 mA as FFFh, linear at about 0.0039 mA a step.
// R7 - The code clamps at 000h below 4 mA and at FFFh above 20 mA.
// R8 - Status byte bits 0 and 1 show the first and second switch inputs, 1 when on.
// R9 - Status bits 2 to 4 are set when current is at or above limits 0, 1 and 2.
// R10 - Output byte bit 0 turns the switched output on when 1 and off when 0.
// R11 - The status lamp is off below 3.2 mA and steady green from 3.2 to 21.5 mA.
// R12 - The status lamp flashes red above 21.5 mA and is steady red on a short circuit.
// R13 - The output lamp is green while the switched output is on and off otherwise.
// R14 - Each switch input lamp is green while its input is on and off otherwise.
// R15 - A short circuit outranks range indication, and status bits 5 to 7 read zero.
// R16 - Output byte bits 1 to 7 have no effect on anything.
module clip_top #(
    parameter FLASH_HALF_CYCLES = `CLIP_FLASH_HALF_MS * `CLIP_CLK_KHZ,
    parameter FLASH_CNT_W       = 25
) (
    // Clock and reset
    input  wire                    i_clk,
    input  wire                    i_sys_rst,
    // Converter result, same clock
    input  wire                    i_adc_valid,
    input  wire [`CLIP_CUR_W-1:0]  i_adc_ua,
    // Pins
    input  wire                    i_first_switch_input,
    input  wire                    i_second_switch_input,
    input  wire                    i_short_det,
    // Process data to and from the head station
    output reg  [7:0]              o_pd_in0,
    output reg  [7:0]              o_pd_in1,
    output reg  [7:0]              o_pd_in2,
    input  wire [7:0]              i_pd_out,
    // Switched output
    output reg                     o_switch_out,
    // Lamps
    output reg                     o_stat_green,
    output reg                     o_stat_red,
    output reg                     o_out_green,
    output reg                     o_in0_green,
    output reg                     o_in1_green,
    // Register port
    input  wire [`CLIP_ADDR_W-1:0] i_addr,
    input  wire [31:0]             i_wr_data,
    input  wire                    i_wr,
    input  wire                    i_rd,
    output reg  [31:0]             o_rd_data,
    // Interrupt
    output wire                    o_irq
);

    // Synchronised pins
    wire [2:0] pins_lvl;
    wire       sw0;
    wire       sw1;
    wire       short_lvl;

    clip_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     ({i_short_det, i_second_switch_input, i_first_switch_input}),
        .o_level   (pins_lvl)
    );

    assign sw0       = pins_lvl[0];
    assign sw1       = pins_lvl[1];
    assign short_lvl = pins_lvl[2];

    // Latest converter sample
    reg [`CLIP_CUR_W-1:0] cur_reg;
    reg                   cur_seen_reg;

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cur_reg      <= {`CLIP_CUR_W{1'b0}};
            cur_seen_reg <= 1'b0;
        end else if (i_adc_valid) begin
            cur_reg      <= i_adc_ua;
            cur_seen_reg <= 1'b1;
        end
    end

    // Range classification
    wire wire_break_flag;
    wire below_span_flag;
    wire above_span_flag;
    wire overflow_flag;

    assign wire_break_flag = cur_reg < `CLIP_UA_WIRE_BREAK; // R4
    assign below_span_flag = !wire_break_flag && cur_reg < `CLIP_UA_SPAN_LO; // R4
    assign above_span_flag = cur_reg > `CLIP_UA_SPAN_HI && !overflow_flag; // R5
    assign overflow_flag   = cur_reg > `CLIP_UA_OVERFLOW; // R5

    // Scaling: constant multiply instead of a divider
    wire [`CLIP_CUR_W-1:0] span_off;
    wire [`CLIP_PROD_W-1:0] prod;
    wire [11:0]             lin_code;
    reg  [11:0]             code;

    assign span_off = cur_reg - `CLIP_UA_SPAN_LO;
    assign prod     = span_off * `CLIP_SCALE_K; // R6
    assign lin_code = prod[`CLIP_SCALE_SHIFT+11:`CLIP_SCALE_SHIFT]; // R6

    always @* begin
        if (cur_reg < `CLIP_UA_SPAN_LO) begin
            code = `CLIP_CODE_MIN; // R7
        end else if (cur_reg >= `CLIP_UA_SPAN_HI) begin
            code = `CLIP_CODE_MAX; // R7
        end else begin
            code = lin_code;
        end
    end

    // Limit registers
    reg [`CLIP_CUR_W-1:0] limit_reg [0:`CLIP_NUM_LIMITS-1];
    wire [`CLIP_NUM_LIMITS-1:0] lim_hit;

    genvar g;
    generate
        for (g = 0; g < `CLIP_NUM_LIMITS; g = g + 1) begin : g_lim
            assign lim_hit[g] = cur_reg >= limit_reg[g]; // R9
        end
    endgenerate

    // Measurement word and status byte
    wire [15:0] meas_word;
    wire [7:0]  stat_byte;

    assign meas_word = {overflow_flag, above_span_flag, below_span_flag, // R3
                        wire_break_flag, code}; // R2
    assign stat_byte = {3'h0, lim_hit, sw1, sw0}; // R8 R9 R15

    // Process image update
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pd_in0     <= 8'h00;
            o_pd_in1     <= 8'h00;
            o_pd_in2     <= 8'h00;
            o_switch_out <= 1'b0;
        end else begin
            o_pd_in0     <= meas_word[7:0]; // R1
            o_pd_in1     <= meas_word[15:8]; // R1
            o_pd_in2     <= stat_byte; // R1
            o_switch_out <= i_pd_out[`CLIP_BIT_SWITCH_OUT]; // R10 R16
        end
    end

    // Lamps
    wire flash_phase;

    clip_blink #(
        .HALF_CYCLES (FLASH_HALF_CYCLES),
        .CNT_W       (FLASH_CNT_W)
    ) u_blink (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (overflow_flag),
        .o_phase   (flash_phase)
    );

    // Before the first sample the lamp shows nothing rather than a false break
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_stat_green <= 1'b0;
            o_stat_red   <= 1'b0;
            o_out_green  <= 1'b0;
            o_in0_green  <= 1'b0;
            o_in1_green  <= 1'b0;
        end else begin
            if (short_lvl) begin
                o_stat_green <= 1'b0; // R15
                o_stat_red   <= 1'b1; // R12
            end else if (overflow_flag) begin
                o_stat_green <= 1'b0;
                o_stat_red   <= flash_phase; // R12
            end else if (wire_break_flag) begin
                o_stat_green <= 1'b0; // R11
                o_stat_red   <= 1'b0;
            end else begin
                o_stat_green <= cur_seen_reg; // R11
                o_stat_red   <= 1'b0;
            end
            o_out_green <= o_switch_out; // R13
            o_in0_green <= sw0; // R14
            o_in1_green <= sw1; // R14
        end
    end

    // Interrupt events on rising conditions
    reg  [`CLIP_IRQ_W-1:0] cond_d_reg;
    reg  [`CLIP_IRQ_W-1:0] irq_stat_reg;
    reg  [`CLIP_IRQ_W-1:0] irq_en_reg;
    wire [`CLIP_IRQ_W-1:0] cond;
    wire [`CLIP_IRQ_W-1:0] events;
    wire [`CLIP_IRQ_W-1:0] clr_mask;

    assign cond     = {|lim_hit, short_lvl, overflow_flag, wire_break_flag & cur_seen_reg};
    assign events   = cond & ~cond_d_reg;
    assign clr_mask = (i_wr && i_addr == `CLIP_REG_IRQ_CLR) ?
                      i_wr_data[`CLIP_IRQ_W-1:0] : {`CLIP_IRQ_W{1'b0}};

    // Set beats clear in the same cycle
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cond_d_reg   <= {`CLIP_IRQ_W{1'b0}};
            irq_stat_reg <= {`CLIP_IRQ_W{1'b0}};
        end else begin
            cond_d_reg   <= cond;
            irq_stat_reg <= (irq_stat_reg & ~clr_mask) | events;
        end
    end

    assign o_irq = |(irq_stat_reg & irq_en_reg);

    // Register writes
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            limit_reg[0] <= `CLIP_LIMIT0_RST;
            limit_reg[1] <= `CLIP_LIMIT1_RST;
            limit_reg[2] <= `CLIP_LIMIT2_RST;
            irq_en_reg   <= {`CLIP_IRQ_W{1'b0}};
        end else if (i_wr) begin
            case (i_addr)
                `CLIP_REG_LIMIT0: limit_reg[0] <= i_wr_data[`CLIP_CUR_W-1:0];
                `CLIP_REG_LIMIT1: limit_reg[1] <= i_wr_data[`CLIP_CUR_W-1:0];
                `CLIP_REG_LIMIT2: limit_reg[2] <= i_wr_data[`CLIP_CUR_W-1:0];
                `CLIP_REG_IRQ_EN: irq_en_reg   <= i_wr_data[`CLIP_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Register reads, data the cycle after the strobe only
    reg [31:0] rd_mux;

    always @* begin
        case (i_addr)
            `CLIP_REG_LIMIT0:   rd_mux = {16'h0000, limit_reg[0]};
            `CLIP_REG_LIMIT1:   rd_mux = {16'h0000, limit_reg[1]};
            `CLIP_REG_LIMIT2:   rd_mux = {16'h0000, limit_reg[2]};
            `CLIP_REG_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_reg};
            `CLIP_REG_IRQ_EN:   rd_mux = {28'h0000000, irq_en_reg};
            `CLIP_REG_MEAS:     rd_mux = {16'h0000, o_pd_in1, o_pd_in0};
            `CLIP_REG_STATUS:   rd_mux = {24'h000000, o_pd_in2};
            default:            rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data <= 32'h00000000;
        end else if (i_rd) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= 32'h00000000;
        end
    end

endmodule

// ---- clip_top_assertions.sv ----
module clip_top_assertions (
    // Clock and reset
    input logic        i_clk,
    input logic        i_sys_rst,
    // Stimulus seen at the ports
    input logic        i_adc_valid,
    input logic [15:0] i_adc_ua,
    input logic [7:0]  i_pd_out,
    // Process image and lamps
    input logic [7:0]  o_pd_in0,
    input logic [7:0]  o_pd_in1,
    input logic [7:0]  o_pd_in2,
    input logic        o_out_green,
    input logic        o_in0_green,
    input logic        o_in1_green,
    input logic        o_stat_green,
    input logic        o_stat_red
);
    logic [1:0]  up_reg;
    wire  [15:0] word = {o_pd_in1, o_pd_in0};
    // Two-deep past is only meaningful once two edges have passed since reset
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire_break_a: assert property (i_adc_valid && i_adc_ua < 16'h0c80
        |-> ##2 word == 16'h1000) else $error("wire break word wrong");
    below_span_a: assert property (i_adc_valid && i_adc_ua inside {[16'h0c80:16'h0f9f]}
        |-> ##2 word == 16'h2000) else $error("below span word wrong");
    above_span_a: assert property (i_adc_valid && i_adc_ua inside {[16'h4e21:16'h53fc]}
        |-> ##2 word == 16'h4fff) else $error("above span word wrong");
    overflow_word_a: assert property (i_adc_valid && i_adc_ua > 16'h53fc
        |-> ##2 word == 16'h8fff) else $error("overflow word wrong");
    reserved_zero_a: assert property (o_pd_in2[7:5] == 3'h0)
        else $error("reserved status bits set");
    out_lamp_a: assert property (up_reg == 2'h3 |-> o_out_green == $past(i_pd_out[0], 2))
        else $error("output lamp wrong");
    in_lamps_a: assert property ($changed(o_pd_in2[1:0])
        |-> ##[0:1] {o_in1_green, o_in0_green} == o_pd_in2[1:0])
        else $error("input lamps wrong");
    stat_colour_a: assert property (!(o_stat_green && o_stat_red))
        else $error("status lamp two colours");
endmodule

bind clip_top clip_top_assertions chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_adc_valid(i_adc_valid), .i_adc_ua(i_adc_ua), .i_pd_out(i_pd_out),
    .o_pd_in0(o_pd_in0), .o_pd_in1(o_pd_in1), .o_pd_in2(o_pd_in2),
    .o_out_green(o_out_green), .o_in0_green(o_in0_green), .o_in1_green(o_in1_green),
    .o_stat_green(o_stat_green), .o_stat_red(o_stat_red));

// ---- clip_head_model.sv ----
module clip_head_model (
    // Clock
    input  wire logic       i_clk,
    // Input image from the device
    input  wire logic [7:0] i_pd_in0,
    input  wire logic [7:0] i_pd_in1,
    input  wire logic [7:0] i_pd_in2,
    // Output byte to the device
    output logic [7:0]      o_pd_out
);
    wire [23:0] image = {i_pd_in2, i_pd_in1, i_pd_in0};
    initial o_pd_out = 8'h00;
    // Cycle update lands just after an edge, as a real exchange would
    task automatic send(input logic [7:0] b);
        @(posedge i_clk);
        o_pd_out <= b;
    endtask
endmodule

// ---- clip_top_tb_top.sv ----
module clip_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        valid = 1'b0;
    logic [15:0] ua = 16'h0000;
    logic [1:0]  sw = 2'h0;
    logic        shrt = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  pd0, pd1, pd2, pdo;
    logic        swo, sg, sr, og, g0, g1, irq;
    logic [31:0] rdat;
    int          fails = 0;
    int          check_count = 0;
    int          cyc = 0;

    always #5 clk = ~clk;

    clip_top #(.FLASH_HALF_CYCLES(8), .FLASH_CNT_W(4)) dut_u (.i_clk(clk), .i_sys_rst(rst),
        .i_adc_valid(valid), .i_adc_ua(ua), .i_first_switch_input(sw[0]),
        .i_second_switch_input(sw[1]), .i_short_det(shrt), .o_pd_in0(pd0), .o_pd_in1(pd1),
        .o_pd_in2(pd2), .i_pd_out(pdo), .o_switch_out(swo), .o_stat_green(sg),
        .o_stat_red(sr), .o_out_green(og), .o_in0_green(g0), .o_in1_green(g1),
        .i_addr(addr), .i_wr_data(wdat), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .o_irq(irq));
    clip_head_model head_u (.i_clk(clk), .i_pd_in0(pd0), .i_pd_in1(pd1), .i_pd_in2(pd2),
        .o_pd_out(pdo));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic samp(input logic [15:0] u);
        @(posedge clk);
        ua <= u;
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        tick(1);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic t_scale;
        logic [15:0] u [0:11] = '{16'h0000, 16'h0c7f, 16'h0c80, 16'h0f9f, 16'h0fa0, 16'h0fa4,
            16'h4e1f, 16'h4e20, 16'h4e21, 16'h53fc, 16'h53fd, 16'h9c40};
        logic [15:0] e [0:11] = '{16'h1000, 16'h1000, 16'h2000, 16'h2000, 16'h0000, 16'h0001,
            16'h0ffe, 16'h0fff, 16'h4fff, 16'h4fff, 16'h8fff, 16'h8fff};
        for (int i = 0; i < 12; i++) begin
            samp(u[i]);
            chk({16'h0, head_u.image[15:0]}, {16'h0, e[i]}, "word");
        end
        $display("test scale done");
    endtask
    task automatic t_limits;
        logic [31:0] d;
        logic [15:0] u [0:3] = '{16'h1f3f, 16'h1f40, 16'h2ee0, 16'h3e80};
        logic [7:0]  e [0:3] = '{8'h00, 8'h04, 8'h0c, 8'h1c};
        for (int i = 0; i < 4; i++) begin
            samp(u[i]);
            chk({24'h0, pd2}, {24'h0, e[i]}, "limit bits");
        end
        reg_rd(8'h04, d);
        chk(d, 32'h2ee0, "limit1 reset");
        reg_wr(8'h00, 32'h1388);
        samp(16'h1388);
        chk({24'h0, pd2}, 32'h04, "limit at");
        samp(16'h1387);
        chk({24'h0, pd2}, 32'h00, "limit below");
        $display("test limits done");
    endtask
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            sw <= i[1:0];
            tick(6);
            chk({22'h0, g1, g0, pd2}, {22'h0, i[1:0], 6'h0, i[1:0]}, "switch in");
        end
        $display("test pins done");
    endtask
    task automatic t_output;
        logic [7:0] v [0:3] = '{8'h01, 8'hfe, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++) begin
            head_u.send(v[i]);
            tick(3);
            chk({30'h0, swo, og}, {30'h0, v[i][0], v[i][0]}, "switch out");
        end
        $display("test output done");
    endtask
    task automatic lamp_cnt(input logic [7:0] lo, input logic [7:0] hi, input logic gexp);
        int nr = 0;
        int ng = 0;
        repeat (40) begin
            tick(1);
            nr += sr;
            ng += sg;
        end
        chk({31'h0, nr >= lo && nr <= hi}, 32'h1, "red count");
        chk(ng, gexp ? 40 : 0, "green count");
    endtask
    task automatic t_lamp;
        samp(16'h2710);
        tick(3);
        lamp_cnt(8'h00, 8'h00, 1'b1);
        samp(16'h03e8);
        tick(3);
        lamp_cnt(8'h00, 8'h00, 1'b0);
        samp(16'h53fd);
        tick(3);
        lamp_cnt(8'h0c, 8'h1c, 1'b0);
        @(posedge clk);
        shrt <= 1'b1;
        tick(6);
        lamp_cnt(8'h28, 8'h28, 1'b0);
        @(posedge clk);
        shrt <= 1'b0;
        $display("test lamp done");
    endtask
    task automatic t_irq;
        logic [31:0] d;
        // Break, overflow, short and limit rises all happened in earlier tests
        reg_rd(8'h0c, d);
        chk(d, 32'hf, "all events sticky");
        reg_wr(8'h10, 32'hf);
        reg_rd(8'h0c, d);
        chk(d, 32'h0, "all events cleared");
        reg_wr(8'h14, 32'h2);
        chk(irq, 0, "irq idle");
        samp(16'h2710);
        samp(16'h53fd);
        tick(2);
        chk(irq, 1, "irq raised");
        reg_rd(8'h0c, d);
        chk(d[1], 1, "irq status");
        reg_wr(8'h14, 32'h0);
        chk(irq, 0, "irq masked");
        reg_wr(8'h14, 32'h2);
        chk(irq, 1, "irq unmasked");
        reg_wr(8'h10, 32'h2);
        chk(irq, 0, "irq cleared");
        reg_rd(8'h10, d);
        chk(d, 0, "clear reads zero");
        reg_rd(8'h40, d);
        chk(d, 0, "unmapped");
        reg_wr(8'h18, 32'h0);
        reg_rd(8'h18, d);
        chk(d, 32'h8fff, "word read");
        $display("test irq done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_scale();
        t_limits();
        t_pins();
        t_output();
        t_lamp();
        t_irq();
        end_of_test();
    end
endmodule
